/* File: hdl/cpwm_consts.svh */
// Offsets, field positions, reset values and counts of the compare/PWM unit
// Assumes inclusion by bare name from the package and the top module
`ifndef CPWM_CONSTS_SVH
`define CPWM_CONSTS_SVH

// ==========================================
// Register offsets
`define CPWM_OFS_FLAGS      8'h0c
`define CPWM_OFS_T1_LOW     8'h0e
`define CPWM_OFS_T1_HIGH    8'h0f
`define CPWM_OFS_T1_CTRL    8'h10
`define CPWM_OFS_T2_COUNT   8'h11
`define CPWM_OFS_T2_CTRL    8'h12
`define CPWM_OFS_DUTY_LOW   8'h15
`define CPWM_OFS_DUTY_HIGH  8'h16
`define CPWM_OFS_UNIT_CTRL  8'h17
`define CPWM_OFS_DIR        8'h87
`define CPWM_OFS_ENABLES    8'h8c
`define CPWM_OFS_PERIOD     8'h92

// ==========================================
// Field positions and masks
`define CPWM_FLAG_T1_OVF    0
`define CPWM_FLAG_T2        1
`define CPWM_FLAG_MATCH     2
`define CPWM_FLAGS_MASK     8'h07
`define CPWM_ENABLES_MASK   8'h07
`define CPWM_T1_RUN         0
`define CPWM_T1_PS_LSB      4
`define CPWM_T1_CTRL_MASK   8'h3f
`define CPWM_T2_PS_LSB      0
`define CPWM_T2_RUN         2
`define CPWM_T2_POST_LSB    3
`define CPWM_T2_CTRL_MASK   8'h7f
`define CPWM_UC_DUTY_LSB    4
`define CPWM_UC_MASK        8'h3f
`define CPWM_PIN_BIT        2

// ==========================================
// Reset values
`define CPWM_RST_ZERO       8'h00
`define CPWM_RST_DIR        8'hff
`define CPWM_RST_PERIOD     8'hff

// ==========================================
// Mode select codes
`define CPWM_MODE_OFF       4'h0
`define CPWM_MODE_SET       4'h8
`define CPWM_MODE_CLR       4'h9
`define CPWM_MODE_SWI       4'ha
`define CPWM_MODE_SEV       4'hb

// ==========================================
// Timing
`define CPWM_TOSC_NS        8
`define CPWM_Q_LAST         2'h3

`endif

/* File: hdl/cpwm_pkg.sv */
// Types of the compare/PWM unit
// Assumes the constants header is on the include path
package cpwm_pkg;
    `include "cpwm_consts.svh"

    // ==========================================
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cpwm_bus_req_t;

    // ==========================================
    // Unit pin drive
    typedef struct packed {
        logic out;
        logic oe;
    } cpwm_pin_t;

    // ==========================================
    // Decoded unit modes
    typedef enum logic [6:0] {
        CPWM_OFF  = 7'h01,
        CPWM_SET  = 7'h02,
        CPWM_CLR  = 7'h04,
        CPWM_SWI  = 7'h08,
        CPWM_SEV  = 7'h10,
        CPWM_PWM  = 7'h20,
        CPWM_CAPT = 7'h40
    } cpwm_mode_t;
endpackage : cpwm_pkg

/* File: hdl/cpwm_top.sv */
// Compare and PWM unit with its timers and register file
// Assumes synchronous register port and one clock mclk
//
// Behaviour
// - Compare value constantly matched against timer one
// - Match sets, clears or keeps pin by mode
// - Match flag set with pin action
// - Zero control write forces compare latch low
// - Software interrupt mode only sets flag
// - Special event resets timer one, starts conversion
// - Special event reset sets no overflow flag
// - Zero control write forces PWM latch low
// - Period is (limit+1) times 4 times prescale
// - Timer two clears after reaching period limit
// - Period end sets pin unless duty zero
// - Period end latches duty into buffers
// - Postscaler only paces separate update flag
// - Duty is low register plus two bits
// - High time is duty times clock times prescale
// - Duty writes take effect at period end
// - Duty high byte read only in PWM
// - Duty double buffered for glitchless output
// - Pin clears when buffered duty meets count
// - Duty beyond period never clears pin
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module cpwm_top
    import cpwm_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire cpwm_bus_req_t bus,
    input  wire logic          adc_enable,
    output var  logic [7:0]    rdata,
    output var  cpwm_pin_t     pin,
    output var  logic          peripheral_irq,
    output var  logic          adc_start
);
    `include "cpwm_consts.svh"

    // ==========================================
    // Functions
    function automatic logic hit(input cpwm_bus_req_t b, input logic [7:0] ofs);
        return b.wr && (b.addr == ofs);
    endfunction : hit

    function automatic cpwm_mode_t decode_mode(input logic [3:0] sel);
        logic [3:0] s;
        s = sel;
        if (s[3:2] == 2'h3) begin
            return CPWM_PWM;
        end
        case (s)
            `CPWM_MODE_SET: return CPWM_SET;
            `CPWM_MODE_CLR: return CPWM_CLR;
            `CPWM_MODE_SWI: return CPWM_SWI;
            `CPWM_MODE_SEV: return CPWM_SEV;
            4'h4, 4'h5, 4'h6, 4'h7: return CPWM_CAPT;
            default: return CPWM_OFF;
        endcase
    endfunction : decode_mode

    function automatic logic pre_done(input logic [3:0] cnt, input logic [3:0] mask);
        return (cnt & mask) == mask;
    endfunction : pre_done

    // ==========================================
    // Storage
    logic [1:0] qphase;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [7:0] t1_ctrl;
    logic [2:0] t1_pre;
    logic [7:0] t2_count;
    logic [7:0] t2_ctrl;
    logic [3:0] t2_pre;
    logic [3:0] t2_post;
    logic [7:0] period;
    logic [7:0] duty_low;
    logic [7:0] duty_high;
    logic [1:0] duty_lsb_latch;
    logic [7:0] unit_ctrl;
    logic [7:0] dir;
    logic [7:0] enables;
    logic [2:0] flags;
    logic       pin_latch;
    logic       cmp_eq_q;

    // ==========================================
    // Decode
    cpwm_mode_t mode;
    logic       instr_tick;
    logic       cmp_active;
    logic       pwm_on;
    logic [3:0] t1_mask;
    logic [3:0] t2_mask;
    logic       t1_tick;
    logic       t2_tick;
    logic       cmp_eq;
    logic       match_ev;
    logic       sev_reset;
    logic       t1_wr;
    logic       t1_ovf;
    logic       period_end;
    logic       t2_flag_ev;
    logic [1:0] low2;
    logic [9:0] next_duty;
    logic       pwm_clear;
    logic       ctrl_zero;
    logic       next_pin;
    logic [7:0] rd_value;

    assign mode       = decode_mode(unit_ctrl[3:0]);
    assign instr_tick = (qphase == `CPWM_Q_LAST);
    assign cmp_active = (mode == CPWM_SET) || (mode == CPWM_CLR) ||
                        (mode == CPWM_SWI) || (mode == CPWM_SEV);
    assign pwm_on     = (mode == CPWM_PWM);
    assign ctrl_zero  = hit(bus, `CPWM_OFS_UNIT_CTRL) && (bus.wdata == 8'h00);

    always_comb begin
        case (t1_ctrl[`CPWM_T1_PS_LSB +: 2])
            2'h0:    t1_mask = 4'h0;
            2'h1:    t1_mask = 4'h1;
            2'h2:    t1_mask = 4'h3;
            default: t1_mask = 4'h7;
        endcase
        case (t2_ctrl[`CPWM_T2_PS_LSB +: 2])
            2'h0:    t2_mask = 4'h0;
            2'h1:    t2_mask = 4'h3;
            default: t2_mask = 4'hf;
        endcase
    end

    assign t1_tick = instr_tick && t1_ctrl[`CPWM_T1_RUN] && pre_done({1'b0, t1_pre}, t1_mask);
    assign t2_tick = instr_tick && t2_ctrl[`CPWM_T2_RUN] && pre_done(t2_pre, t2_mask);

    // ==========================================
    // Compare path
    assign cmp_eq    = ({duty_high, duty_low} == {t1_high, t1_low});
    assign match_ev  = cmp_active && cmp_eq && !cmp_eq_q;
    assign sev_reset = match_ev && (mode == CPWM_SEV);
    assign t1_wr     = hit(bus, `CPWM_OFS_T1_LOW) || hit(bus, `CPWM_OFS_T1_HIGH);
    assign t1_ovf    = t1_tick && !t1_wr && !sev_reset && ({t1_high, t1_low} == 16'hffff);

    // ==========================================
    // PWM path
    assign period_end = t2_tick && (t2_count == period);
    assign t2_flag_ev = period_end && (t2_post == t2_ctrl[`CPWM_T2_POST_LSB +: 4]);
    assign next_duty  = {duty_low, unit_ctrl[`CPWM_UC_DUTY_LSB +: 2]};

    always_comb begin
        case (t2_ctrl[`CPWM_T2_PS_LSB +: 2])
            2'h0:    low2 = qphase;
            2'h1:    low2 = t2_pre[1:0];
            default: low2 = t2_pre[3:2];
        endcase
    end

    // Count beyond the period never reaches a larger duty
    assign pwm_clear = pwm_on && ({t2_count, low2} == {duty_high, duty_lsb_latch});

    always_comb begin
        next_pin = pin_latch;
        if (ctrl_zero) begin
            next_pin = 1'b0;
        end else if (pwm_on) begin
            if (period_end) begin
                next_pin = (next_duty != 10'h000);
            end else if (pwm_clear) begin
                next_pin = 1'b0;
            end
        end else if (match_ev) begin
            case (mode)
                CPWM_SET: next_pin = 1'b1;
                CPWM_CLR: next_pin = 1'b0;
                default:  next_pin = pin_latch;
            endcase
        end
    end

    // ==========================================
    // Phase counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            qphase <= 2'h0;
        end else begin
            qphase <= qphase + 2'h1;
        end
    end

    // ==========================================
    // Timer one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            t1_low  <= `CPWM_RST_ZERO;
            t1_high <= `CPWM_RST_ZERO;
            t1_pre  <= 3'h0;
        end else if (sev_reset) begin
            t1_low  <= `CPWM_RST_ZERO;
            t1_high <= `CPWM_RST_ZERO;
            t1_pre  <= 3'h0;
        end else if (t1_wr) begin
            if (hit(bus, `CPWM_OFS_T1_LOW)) begin
                t1_low <= bus.wdata;
            end
            if (hit(bus, `CPWM_OFS_T1_HIGH)) begin
                t1_high <= bus.wdata;
            end
            t1_pre <= 3'h0;
        end else begin
            if (instr_tick && t1_ctrl[`CPWM_T1_RUN]) begin
                t1_pre <= t1_pre + 3'h1;
            end
            if (t1_tick) begin
                {t1_high, t1_low} <= {t1_high, t1_low} + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmp_eq_q <= 1'b0;
        end else begin
            cmp_eq_q <= cmp_eq;
        end
    end

    // ==========================================
    // Timer two
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            t2_count <= `CPWM_RST_ZERO;
            t2_pre   <= 4'h0;
            t2_post  <= 4'h0;
        end else if (hit(bus, `CPWM_OFS_T2_COUNT) || hit(bus, `CPWM_OFS_T2_CTRL)) begin
            if (hit(bus, `CPWM_OFS_T2_COUNT)) begin
                t2_count <= bus.wdata;
            end
            t2_pre  <= 4'h0;
            t2_post <= 4'h0;
        end else begin
            if (instr_tick && t2_ctrl[`CPWM_T2_RUN]) begin
                t2_pre <= t2_pre + 4'h1;
            end
            if (period_end) begin
                t2_count <= 8'h00;
                t2_post  <= t2_flag_ev ? 4'h0 : t2_post + 4'h1;
            end else if (t2_tick) begin
                t2_count <= t2_count + 8'h01;
            end
        end
    end

    // ==========================================
    // Configuration registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            t1_ctrl   <= `CPWM_RST_ZERO;
            t2_ctrl   <= `CPWM_RST_ZERO;
            unit_ctrl <= `CPWM_RST_ZERO;
            dir       <= `CPWM_RST_DIR;
            enables   <= `CPWM_RST_ZERO;
            period    <= `CPWM_RST_PERIOD;
            duty_low  <= `CPWM_RST_ZERO;
        end else begin
            if (hit(bus, `CPWM_OFS_T1_CTRL)) begin
                t1_ctrl <= bus.wdata & `CPWM_T1_CTRL_MASK;
            end
            if (hit(bus, `CPWM_OFS_T2_CTRL)) begin
                t2_ctrl <= bus.wdata & `CPWM_T2_CTRL_MASK;
            end
            if (hit(bus, `CPWM_OFS_UNIT_CTRL)) begin
                unit_ctrl <= bus.wdata & `CPWM_UC_MASK;
            end
            if (hit(bus, `CPWM_OFS_DIR)) begin
                dir <= bus.wdata;
            end
            if (hit(bus, `CPWM_OFS_ENABLES)) begin
                enables <= bus.wdata & `CPWM_ENABLES_MASK;
            end
            if (hit(bus, `CPWM_OFS_PERIOD)) begin
                period <= bus.wdata;
            end
            if (hit(bus, `CPWM_OFS_DUTY_LOW)) begin
                duty_low <= bus.wdata;
            end
        end
    end

    // ==========================================
    // Duty buffer and compare high byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            duty_high      <= `CPWM_RST_ZERO;
            duty_lsb_latch <= 2'h0;
        end else if (pwm_on) begin
            if (period_end) begin
                duty_high      <= next_duty[9:2];
                duty_lsb_latch <= next_duty[1:0];
            end
        end else if (hit(bus, `CPWM_OFS_DUTY_HIGH)) begin
            duty_high <= bus.wdata;
        end
    end

    // ==========================================
    // Pin latch and drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_latch <= 1'b0;
            pin       <= '{out: 1'b0, oe: 1'b0};
        end else begin
            pin_latch <= next_pin;
            pin       <= '{out: next_pin, oe: !dir[`CPWM_PIN_BIT]};
        end
    end

    // ==========================================
    // Flags, interrupt and trigger
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags <= 3'h0;
        end else begin
            // Hardware set wins over a software clear
            flags <= (hit(bus, `CPWM_OFS_FLAGS) ? bus.wdata[2:0] : flags) |
                     {match_ev, t2_flag_ev, t1_ovf};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            peripheral_irq <= 1'b0;
            adc_start      <= 1'b0;
        end else begin
            peripheral_irq <= |(flags & enables[2:0]);
            adc_start      <= sev_reset && adc_enable;
        end
    end

    // ==========================================
    // Read port
    always_comb begin
        case (bus.addr)
            `CPWM_OFS_FLAGS:     rd_value = {5'h00, flags};
            `CPWM_OFS_T1_LOW:    rd_value = t1_low;
            `CPWM_OFS_T1_HIGH:   rd_value = t1_high;
            `CPWM_OFS_T1_CTRL:   rd_value = t1_ctrl;
            `CPWM_OFS_T2_COUNT:  rd_value = t2_count;
            `CPWM_OFS_T2_CTRL:   rd_value = t2_ctrl;
            `CPWM_OFS_DUTY_LOW:  rd_value = duty_low;
            `CPWM_OFS_DUTY_HIGH: rd_value = duty_high;
            `CPWM_OFS_UNIT_CTRL: rd_value = unit_ctrl;
            `CPWM_OFS_DIR:       rd_value = dir;
            `CPWM_OFS_ENABLES:   rd_value = enables;
            `CPWM_OFS_PERIOD:    rd_value = period;
            default:             rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= bus.rd ? rd_value : 8'h00;
        end
    end
endmodule : cpwm_top

`default_nettype wire

/* File: tb/cpwm_top_props.sv */
// Port assertions of the compare/PWM unit
// Assumes binding into cpwm_top, single clock mclk
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_consts.svh"
module cpwm_top_props
    import cpwm_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rst,
    input wire cpwm_bus_req_t bus,
    input wire logic          adc_enable,
    input wire logic [7:0]    rdata,
    input wire cpwm_pin_t     pin,
    input wire logic          peripheral_irq,
    input wire logic          adc_start
);
    // ==========================================
    // Shadows of control writes
    logic [7:0] uc;
    logic [7:0] en;
    logic       wr_uc;
    assign wr_uc = bus.wr && bus.addr == `CPWM_OFS_UNIT_CTRL;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) uc <= 8'h00;
        else if (wr_uc) uc <= bus.wdata;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) en <= 8'h00;
        else if (bus.wr && bus.addr == `CPWM_OFS_ENABLES) en <= bus.wdata;
    end

    // ==========================================
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    chk_oe_dir: assert property (bus.wr && bus.addr == `CPWM_OFS_DIR |-> ##2 pin.oe == !$past(bus.wdata[2], 2))
        else $error("pin enable does not follow direction");
    chk_zero_ctrl: assert property (wr_uc && bus.wdata == 8'h00 |=> !pin.out)
        else $error("zero control write left pin high");
    chk_off_low: assert property (uc == 8'h00 && !wr_uc |=> !pin.out)
        else $error("pin high while unit cleared");
    chk_set_keep: assert property (uc[3:0] == `CPWM_MODE_SET && !wr_uc |=> !$fell(pin.out))
        else $error("pin fell in set mode");
    chk_clr_keep: assert property (uc[3:0] == `CPWM_MODE_CLR && !wr_uc |=> !$rose(pin.out))
        else $error("pin rose in clear mode");
    chk_swi_stable: assert property (uc[3:1] == 3'b101 && !wr_uc |=> $stable(pin.out))
        else $error("pin moved in flag only mode");
    chk_adc_mode: assert property (adc_start |-> $past(uc[3:0]) == `CPWM_MODE_SEV && $past(adc_enable))
        else $error("conversion start outside trigger mode");
    chk_irq_mask: assert property (peripheral_irq |-> $past(en[2:0]) != 3'h0)
        else $error("interrupt with all enables clear");
endmodule : cpwm_top_props

bind cpwm_top cpwm_top_props i_cpwm_top_props (.mclk(mclk), .rst(rst), .bus(bus), .adc_enable(adc_enable),
    .rdata(rdata), .pin(pin), .peripheral_irq(peripheral_irq), .adc_start(adc_start));
`default_nettype wire

/* File: tb/cpwm_pin_load.sv */
// Pin load with pull-up and watcher of conversion starts
// Assumes single clock mclk
`timescale 1ns/100ps
`default_nettype none
module cpwm_pin_load
    import cpwm_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst,
    input  wire cpwm_pin_t pin,
    input  wire logic      adc_start,
    output var  logic      lvl,
    output var  int        adc_count
);
    // ==========================================
    // Pin net and converter
    assign lvl = pin.oe ? pin.out : 1'b1;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) adc_count <= 0;
        else if (adc_start) adc_count <= adc_count + 1;
    end
endmodule : cpwm_pin_load
`default_nettype wire

/* File: tb/compare_and_pwm_unit_bench.sv */
// Self-checking bench of the compare/PWM unit
// Assumes the pin load model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module compare_and_pwm_unit_bench
    import cpwm_pkg::*;
;
    logic          mclk;
    logic          rst;
    cpwm_bus_req_t bus;
    logic          adc_enable;
    logic [7:0]    rdata;
    cpwm_pin_t     pin;
    logic          peripheral_irq;
    logic          adc_start;
    logic          lvl;
    int            adc_count;
    int            n_mismatch = 0;
    int            num_checks = 0;
    int            cyc = 0;
    int            seed;
    int            i, p, ps, du, du2, hi, lo, n, t1p;
    logic [7:0]    c, d;
    logic [7:0]    ra [13] = '{8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h87, 8'h8c, 8'h92, 8'h20};
    logic [7:0]    rv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};

    cpwm_top i_cpwm_top (.mclk(mclk), .rst(rst), .bus(bus), .adc_enable(adc_enable), .rdata(rdata), .pin(pin),
        .peripheral_irq(peripheral_irq), .adc_start(adc_start));
    cpwm_pin_load i_cpwm_pin_load (.mclk(mclk), .rst(rst), .pin(pin), .adc_start(adc_start), .lvl(lvl),
        .adc_count(adc_count));

    // ==========================================
    // Clock, timeout and helpers
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            results();
        end
    end
    task results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic int exp_period(input int pl, input int pf);
        return (pl + 1) * 4 * pf;
    endfunction : exp_period
    function automatic logic near(input int seen, input int exp, input int tol);
        return seen >= exp - tol && seen <= exp + tol;
    endfunction : near
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge mclk);
        bus <= '{a, v, 1'b0, 1'b0};
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus <= '{a, 8'h00, 1'b0, 1'b0};
        @(negedge mclk);
        v = rdata;
    endtask : rd
    task meas(output int h, output int l);
        int k;
        h = 0;
        l = 0;
        for (k = 0; k < 3000 && lvl !== 1'b0; k++) @(negedge mclk);
        for (k = 0; k < 3000 && lvl !== 1'b1; k++) @(negedge mclk);
        for (k = 0; k < 3000 && lvl === 1'b1; k++) begin @(negedge mclk); h++; end
        for (k = 0; k < 3000 && lvl !== 1'b1; k++) begin @(negedge mclk); l++; end
    endtask : meas
    task count_lvl(input int cycles, input logic v, output int cnt);
        cnt = 0;
        repeat (cycles) begin
            @(negedge mclk);
            if (lvl === v) cnt++;
        end
    endtask : count_lvl
    task cmp_run(input logic [3:0] mode, input logic exp_pin);
        int k;
        int a0;
        wr(8'h0c, 8'h00);
        wr(8'h17, {4'h0, mode});
        wr(8'h0f, 8'h00);
        wr(8'h0e, 8'h00);
        a0 = adc_count;
        for (k = 0; k < 2000 && peripheral_irq !== 1'b1; k++) @(negedge mclk);
        check(near(k, 4 * c * (1 << t1p), 12 * (1 << t1p)), 1'b1);
        check(pin.out, exp_pin);
        rd(8'h0c, d);
        check(d, 8'h04);
        rd(8'h0e, d);
        check(d < 8'h03, mode == `CPWM_MODE_SEV);
        check(adc_count != a0, mode == `CPWM_MODE_SEV && adc_enable);
    endtask : cmp_run

    // ==========================================
    // Main sequence
    initial begin
        seed = 32'h7ff2;
        rst = 1'b1;
        bus = '0;
        adc_enable = 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 13; i++) begin
            rd(ra[i], d);
            check(d, rv[i]);
        end
        c = 8'h08 + 8'($random(seed) & 32'h1f);
        t1p = {$random(seed)} % 4;
        wr(8'h87, 8'hfb);
        wr(8'h8c, 8'h04);
        wr(8'h10, {2'b00, t1p[1:0], 4'h1});
        wr(8'h16, 8'h00);
        wr(8'h15, c);
        @(negedge mclk);
        check(pin.oe, 1'b1);
        cmp_run(`CPWM_MODE_SET, 1'b1);
        wr(8'h17, 8'h00);
        @(negedge mclk);
        check(pin.out, 1'b0);
        cmp_run(`CPWM_MODE_SET, 1'b1);
        cmp_run(`CPWM_MODE_SWI, 1'b1);
        cmp_run(`CPWM_MODE_SEV, 1'b1);
        @(posedge mclk);
        adc_enable <= 1'b0;
        cmp_run(`CPWM_MODE_SEV, 1'b1);
        cmp_run(`CPWM_MODE_CLR, 1'b0);
        p = 3 + ($random(seed) & 7);
        ps = 1 << (2 * ({$random(seed)} % 3));
        du = 1 + ({$random(seed)} % (4 * p + 2));
        wr(8'h92, p[7:0]);
        wr(8'h15, du[9:2]);
        wr(8'h17, {2'b00, du[1:0], 4'h0});
        wr(8'h12, {1'b0, 4'h1, 1'b1, (ps == 16) ? 2'b10 : ((ps == 4) ? 2'b01 : 2'b00)});
        wr(8'h17, {2'b00, du[1:0], 4'hc});
        repeat (2) meas(hi, lo);
        check(hi + lo, exp_period(p, ps));
        check(near(hi, du * ps, 2 * ps), 1'b1);
        wr(8'h16, 8'h55);
        rd(8'h16, d);
        check(d, du[9:2]);
        du2 = (1 + {$random(seed)} % p) * 4 + du[1:0];
        wr(8'h15, du2[9:2]);
        repeat (2) meas(hi, lo);
        check(near(hi, du2 * ps, 2 * ps), 1'b1);
        rd(8'h0c, d);
        check(d[1], 1'b1);
        wr(8'h15, 8'hff);
        repeat (exp_period(p, ps)) @(negedge mclk);
        count_lvl(2 * exp_period(p, ps), 1'b0, n);
        check(n, 0);
        wr(8'h17, 8'h00);
        @(negedge mclk);
        check(pin.out, 1'b0);
        wr(8'h15, 8'h00);
        wr(8'h17, 8'h0c);
        repeat (exp_period(p, ps)) @(negedge mclk);
        count_lvl(2 * exp_period(p, ps), 1'b1, n);
        check(n, 0);
        results();
    end
endmodule : compare_and_pwm_unit_bench
`default_nettype wire
